/* File: rtl/status_and_tick_registers.sv */
/*
 Rolling tick register, summary status, supply and integrity status and memory status registers.
 Assumes read strobes, DSP, memory and report signals come from logic on mclk; supply monitors are asynchronous.
*/
//
// Contract
// [RULE1] A read-only 8-bit rolling counter runs freely and reads its present count.
// [RULE2] A 10-bit prescaler divides the oscillator by 1000; one step per 100 us.
// [RULE3] All status registers are read-only and readable from either serial interface.
// [RULE4] Summary bit 7 is the OR of the three DSP status faults.
// [RULE5] Summary bit 5 follows the communication fault flag.
// [RULE6] Summary bit 4 is the OR of the memory and temperature status bits.
// [RULE7] Summary bit 3 is the OR of the supply and integrity status bits.
// [RULE8] Summary bit 2 shows test mode; only test operation or power cycle clears it.
// [RULE9] Summary bit 1 sets at reset; clears on summary read or status report.
// [RULE10] Summary bit 0 sets at reset; clears when sensor data first becomes valid.
// [RULE11] The host ignores supply flags during power-on or soft reset.
// [RULE12] One shared recovery timer reloads on any supply error; clearing follows disable setting.
// [RULE13] Supply bit 7 sets when supply voltage is reported low.
// [RULE14] Supply bit 3 sets on an analog regulator out-of-range report.
// [RULE15] Supply bit 2 sets on a digital regulator out-of-range report.
// [RULE16] Supply bit 1 sets on an OTP regulator out-of-range report.
// [RULE17] Supply bit 0 sets on an edge seal break and resets to zero.
// [RULE18] Memory fault and temperature bits clear on their register read or status report.
// [RULE19] The OTP write-active bit clears itself when the write finishes.
// [RULE20] The counter resets to zero; reserved bits read zero; writes are ignored.
// [RULE21] Summary resets with bits 7, 1, 0 set and bits 5, 4, 2 clear; here bits 7 and 5 follow dsp_stat and comm_fault_flag.
`timescale 1ns/1ps
module status_and_tick_registers #(
	parameter int DATA_VALID_CYCLES = status_tick_pkg::DATA_VALID_CYCLES
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic rd_req,
	input wire logic [7:0] rd_addr,
	output logic [7:0] rd_data_q,
	output logic rd_valid_q,
	input wire status_tick_pkg::supply_mon_t supply_mon,
	input wire logic supply_report_disable,
	input wire status_tick_pkg::dsp_stat_t dsp_stat,
	input wire logic comm_fault_flag,
	input wire status_tick_pkg::mem_evt_t mem_evt,
	input wire logic otp_write_busy,
	input wire logic test_enter,
	input wire logic test_exit,
	input wire logic summary_reported,
	input wire logic memtemp_reported,
	output logic test_active_flag_q,
	output logic initializing_flag_q
);
	function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] target);
		addr_hit = (addr == target);
	endfunction

	// Reset release synchroniser.
	logic rst_meta_q;
	logic rst_n_q;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rst_meta_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q <= rst_meta_q;
		end
	end

	// Rolling tick counter.
	status_tick_pkg::tick_t tick_q;

	tick_counter #(
		.OSC_CYCLES(status_tick_pkg::OSC_CYCLES),
		.PRESCALE_DIV(status_tick_pkg::PRESCALE_DIV)
	) u_tick (
		.mclk(mclk),
		.rst_n(rst_n_q),
		.count_q(tick_q)
	);

	// Supply monitor synchroniser.
	status_tick_pkg::supply_mon_t sup_meta_q;
	status_tick_pkg::supply_mon_t sup_sync_q;

	always_ff @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			sup_meta_q <= '0;
			sup_sync_q <= '0;
		end else begin
			sup_meta_q <= supply_mon;
			sup_sync_q <= sup_meta_q;
		end
	end

	// Read strobes decoded per register.
	wire rd_summary = rd_req && addr_hit(rd_addr, status_tick_pkg::ADDR_SUMMARY); // RULE9
	wire rd_memtemp = rd_req && addr_hit(rd_addr, status_tick_pkg::ADDR_MEMTEMP); // RULE18

	// Supply flags and shared recovery timer.
	logic [4:0] sup_flag_q;
	logic [4:0] sup_flag_d;
	status_tick_pkg::recover_t recover_q;
	status_tick_pkg::recover_t recover_d;
	wire [4:0] sup_live = {
		sup_sync_q.supply_low, // RULE13
		sup_sync_q.analog_regulator_fault, // RULE14
		sup_sync_q.digital_regulator_fault, // RULE15
		sup_sync_q.otp_regulator_fault, // RULE16
		sup_sync_q.edge_seal_break // RULE17
	};
	wire sup_any = |sup_live;
	wire recover_done = (recover_q == '0) && !sup_any;
	wire [4:0] sup_clear = supply_report_disable ? ~sup_live : {5{recover_done}}; // RULE12

	assign recover_d = sup_any ? status_tick_pkg::recover_t'(status_tick_pkg::RECOVERY_CYCLES - 1) :
		(recover_q == '0) ? recover_q : recover_q - 1'b1; // RULE12
	assign sup_flag_d = sup_live | (sup_flag_q & ~sup_clear);

	always_ff @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			recover_q <= '0;
			sup_flag_q <= status_tick_pkg::SUPPLY_FLAGS_RESET; // RULE17
		end else begin
			recover_q <= recover_d;
			sup_flag_q <= sup_flag_d;
		end
	end

	// Memory and temperature flags, cleared by read or report with set winning.
	logic [3:0] mem_flag_q;
	logic [3:0] mem_flag_d;
	logic write_active_q;
	wire mem_clear = rd_memtemp || memtemp_reported;

	assign mem_flag_d = mem_evt | (mem_flag_q & {4{!mem_clear}}); // RULE18

	always_ff @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			mem_flag_q <= status_tick_pkg::MEM_FLAGS_RESET;
			write_active_q <= 1'b0;
		end else begin
			mem_flag_q <= mem_flag_d;
			write_active_q <= otp_write_busy; // RULE19
		end
	end

	// Test mode, reset-occurred and initializing flags.
	logic reset_occurred_flag_q;
	status_tick_pkg::init_count_t init_cnt_q;
	wire init_last = (init_cnt_q == status_tick_pkg::init_count_t'(DATA_VALID_CYCLES - 1));

	always_ff @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			test_active_flag_q <= status_tick_pkg::TEST_RESET; // RULE21
			reset_occurred_flag_q <= status_tick_pkg::RESET_FLAG_RESET; // RULE21
			initializing_flag_q <= status_tick_pkg::INIT_FLAG_RESET; // RULE21
			init_cnt_q <= '0;
		end else begin
			if (test_enter) begin
				test_active_flag_q <= 1'b1; // RULE8
			end else if (test_exit) begin
				test_active_flag_q <= 1'b0; // RULE8
			end
			if (rd_summary || summary_reported) begin
				reset_occurred_flag_q <= 1'b0; // RULE9
			end
			if (initializing_flag_q) begin
				init_cnt_q <= init_cnt_q + 1'b1;
				if (init_last) begin
					initializing_flag_q <= 1'b0; // RULE10
				end
			end
		end
	end

	// Register images, reserved bits zero.
	wire [7:0] memtemp_img = {mem_flag_q[3], mem_flag_q[2], mem_flag_q[1], write_active_q,
		1'b0, mem_flag_q[0], 1'b0, 1'b0}; // RULE20
	wire [7:0] supply_img = {sup_flag_q[4], 3'h0, sup_flag_q[3:0]}; // RULE20
	wire dsp_fault = dsp_stat.selftest_unfinished | dsp_stat.common_mode_fault | dsp_stat.selftest_fault; // RULE4
	wire [7:0] summary_img = {
		dsp_fault, // RULE4
		1'b0, // RULE20
		comm_fault_flag, // RULE5
		|memtemp_img, // RULE6
		|supply_img, // RULE7
		test_active_flag_q, // RULE8
		reset_occurred_flag_q, // RULE9
		initializing_flag_q // RULE10
	};
	wire [7:0] rd_mux = addr_hit(rd_addr, status_tick_pkg::ADDR_TICK) ? tick_q : // RULE1
		addr_hit(rd_addr, status_tick_pkg::ADDR_SUMMARY) ? summary_img : // RULE3
		addr_hit(rd_addr, status_tick_pkg::ADDR_SUPPLY) ? supply_img : // RULE3
		addr_hit(rd_addr, status_tick_pkg::ADDR_MEMTEMP) ? memtemp_img : 8'h00; // RULE3

	// Read port; the answer carries the value from before any clear-on-read.
	always_ff @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			rd_data_q <= status_tick_pkg::RD_DATA_RESET;
			rd_valid_q <= 1'b0;
		end else begin
			rd_valid_q <= rd_req;
			if (rd_req) begin
				rd_data_q <= rd_mux; // RULE3
			end
		end
	end

	// Helper that measures the spacing between tick steps.
	status_tick_pkg::tick_t tick_prev_q;
	status_tick_pkg::gap_t gap_q;
	logic gap_seen_q;
	wire tick_changed = (tick_q != tick_prev_q);

	always_ff @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			tick_prev_q <= status_tick_pkg::TICK_RESET;
			gap_q <= '0;
			gap_seen_q <= 1'b0;
		end else begin
			tick_prev_q <= tick_q;
			gap_q <= tick_changed ? '0 : gap_q + 1'b1;
			if (tick_changed) begin
				gap_seen_q <= 1'b1;
			end
		end
	end

	property p_tick_step;
		@(posedge mclk) disable iff (!rst_n_q)
		tick_changed |-> tick_q == tick_prev_q + 8'h01;
	endproperty
	a_tick_step: assert property (p_tick_step) else $error("Tick moved by other than one."); // RULE2

	property p_tick_spacing;
		@(posedge mclk) disable iff (!rst_n_q)
		(tick_changed && gap_seen_q) |-> gap_q == status_tick_pkg::gap_t'(status_tick_pkg::TICK_PERIOD_CYCLES - 1);
	endproperty
	a_tick_spacing: assert property (p_tick_spacing) else $error("Tick step spacing wrong."); // RULE2

	property p_tick_read;
		@(posedge mclk) disable iff (!rst_n_q)
		(rd_req && rd_addr == status_tick_pkg::ADDR_TICK) |=> rd_valid_q && rd_data_q == $past(tick_q);
	endproperty
	a_tick_read: assert property (p_tick_read) else $error("Tick read returned wrong value."); // RULE1

	property p_dsp_bit;
		@(posedge mclk) disable iff (!rst_n_q)
		rd_summary |=> rd_data_q[status_tick_pkg::SUM_DSP] == $past(|dsp_stat);
	endproperty
	a_dsp_bit: assert property (p_dsp_bit) else $error("DSP fault bit does not match DSP status."); // RULE4

	property p_comm_bit;
		@(posedge mclk) disable iff (!rst_n_q)
		rd_summary |=> rd_data_q[status_tick_pkg::SUM_COMM] == $past(comm_fault_flag) && !rd_data_q[6];
	endproperty
	a_comm_bit: assert property (p_comm_bit) else $error("Communication bit or reserved bit wrong."); // RULE5

	property p_reset_flag_clear;
		@(posedge mclk) disable iff (!rst_n_q)
		rd_summary |=> rd_data_q[status_tick_pkg::SUM_RESET] == $past(reset_occurred_flag_q) ##1 !reset_occurred_flag_q;
	endproperty
	a_reset_flag_clear: assert property (p_reset_flag_clear) else $error("Reset flag not cleared by read."); // RULE9

	property p_init_fall;
		@(posedge mclk) disable iff (!rst_n_q)
		$fell(initializing_flag_q) |-> $past(init_cnt_q) == status_tick_pkg::init_count_t'(DATA_VALID_CYCLES - 1);
	endproperty
	a_init_fall: assert property (p_init_fall) else $error("Initializing flag cleared early or late."); // RULE10

	property p_supply_set;
		@(posedge mclk) disable iff (!rst_n_q)
		sup_sync_q.supply_low |=> sup_flag_q[4] ##1 recover_q != '0;
	endproperty
	a_supply_set: assert property (p_supply_set) else $error("Supply low flag not set."); // RULE13

	property p_supply_hold;
		@(posedge mclk) disable iff (!rst_n_q)
		($fell(|sup_flag_q) && !$past(supply_report_disable)) |-> $past(recover_q) == '0;
	endproperty
	a_supply_hold: assert property (p_supply_hold) else $error("Supply flags cleared before recovery."); // RULE12

	property p_mem_clear;
		@(posedge mclk) disable iff (!rst_n_q)
		(rd_memtemp && mem_evt == '0) |=> mem_flag_q == '0;
	endproperty
	a_mem_clear: assert property (p_mem_clear) else $error("Memory flags not cleared by read."); // RULE18

	property p_test_hold;
		@(posedge mclk) disable iff (!rst_n_q)
		(test_active_flag_q && !test_exit) |=> test_active_flag_q;
	endproperty
	a_test_hold: assert property (p_test_hold) else $error("Test mode cleared without exit."); // RULE8

	property p_valid_follow;
		@(posedge mclk) disable iff (!rst_n_q)
		1'b1 |=> rd_valid_q == $past(rd_req);
	endproperty
	a_valid_follow: assert property (p_valid_follow) else $error("Read answer strobe does not follow request."); // RULE3

	property p_supply_reserved;
		@(posedge mclk) disable iff (!rst_n_q)
		(rd_req && rd_addr == status_tick_pkg::ADDR_SUPPLY) |=> rd_data_q[6:4] == 3'h0;
	endproperty
	a_supply_reserved: assert property (p_supply_reserved) else $error("Supply reserved bits not zero."); // RULE20

	property p_supply_summary;
		@(posedge mclk) disable iff (!rst_n_q)
		rd_summary |=> rd_data_q[status_tick_pkg::SUM_SUPPLY] == $past(|sup_flag_q);
	endproperty
	a_supply_summary: assert property (p_supply_summary) else $error("Summary supply bit wrong."); // RULE7

	property p_mem_summary;
		@(posedge mclk) disable iff (!rst_n_q)
		rd_summary |=> rd_data_q[status_tick_pkg::SUM_MEM] == $past(|mem_flag_q || write_active_q);
	endproperty
	a_mem_summary: assert property (p_mem_summary) else $error("Summary memory bit wrong."); // RULE6

	property p_test_enter;
		@(posedge mclk) disable iff (!rst_n_q)
		test_enter |=> test_active_flag_q;
	endproperty
	a_test_enter: assert property (p_test_enter) else $error("Test mode not entered."); // RULE8

	property p_init_stays_clear;
		@(posedge mclk) disable iff (!rst_n_q)
		!initializing_flag_q |=> !initializing_flag_q;
	endproperty
	a_init_stays_clear: assert property (p_init_stays_clear) else $error("Initializing flag set again."); // RULE10

	property p_write_active;
		@(posedge mclk) disable iff (!rst_n_q)
		1'b1 |=> write_active_q == $past(otp_write_busy);
	endproperty
	a_write_active: assert property (p_write_active) else $error("Write active bit does not follow write."); // RULE19

	property p_analog_set;
		@(posedge mclk) disable iff (!rst_n_q)
		sup_sync_q.analog_regulator_fault |=> sup_flag_q[3];
	endproperty
	a_analog_set: assert property (p_analog_set) else $error("Analog regulator flag not set."); // RULE14

	property p_digital_set;
		@(posedge mclk) disable iff (!rst_n_q)
		sup_sync_q.digital_regulator_fault |=> sup_flag_q[2];
	endproperty
	a_digital_set: assert property (p_digital_set) else $error("Digital regulator flag not set."); // RULE15

	property p_otp_set;
		@(posedge mclk) disable iff (!rst_n_q)
		sup_sync_q.otp_regulator_fault |=> sup_flag_q[1];
	endproperty
	a_otp_set: assert property (p_otp_set) else $error("OTP regulator flag not set."); // RULE16

	c_tick_wrap: cover property (@(posedge mclk) disable iff (!rst_n_q) tick_prev_q == 8'hff && tick_q == 8'h00);
	c_init_done: cover property (@(posedge mclk) disable iff (!rst_n_q) $fell(initializing_flag_q));
	c_supply_recover: cover property (@(posedge mclk) disable iff (!rst_n_q) $fell(|sup_flag_q));
	c_mem_read: cover property (@(posedge mclk) disable iff (!rst_n_q) rd_memtemp && mem_flag_q != '0);
endmodule

/* File: shared/status_tick_pkg.sv */
/*
 Constants, field positions, reset values and carrier types shared by the status and tick register block.
 Assumes a 200 MHz block clock and a 10 MHz primary oscillator rate that is derived from it.
*/
package status_tick_pkg;

	// Register addresses on the documented read port.
	localparam logic [7:0] ADDR_TICK = 8'h00;
	localparam logic [7:0] ADDR_SUMMARY = 8'h01;
	localparam logic [7:0] ADDR_SUPPLY = 8'h02;
	localparam logic [7:0] ADDR_MEMTEMP = 8'h03;

	// Summary register bit positions.
	localparam int SUM_DSP = 7;
	localparam int SUM_COMM = 5;
	localparam int SUM_MEM = 4;
	localparam int SUM_SUPPLY = 3;
	localparam int SUM_TEST = 2;
	localparam int SUM_RESET = 1;
	localparam int SUM_INIT = 0;

	// Supply and integrity register bit positions.
	localparam int SUP_LOW = 7;
	localparam int SUP_ANALOG = 3;
	localparam int SUP_DIGITAL = 2;
	localparam int SUP_OTP = 1;
	localparam int SUP_SEAL = 0;

	// Memory and temperature register bit positions.
	localparam int MEM_FACTORY = 7;
	localparam int MEM_USER_OTP = 6;
	localparam int MEM_USER_RW = 5;
	localparam int MEM_WRITE_ACTIVE = 4;
	localparam int MEM_TEMP = 2;

	// Values after reset.
	localparam logic [7:0] TICK_RESET = 8'h00;
	localparam logic TEST_RESET = 1'b0;
	localparam logic RESET_FLAG_RESET = 1'b1;
	localparam logic INIT_FLAG_RESET = 1'b1;
	localparam logic [4:0] SUPPLY_FLAGS_RESET = 5'h00;
	localparam logic [3:0] MEM_FLAGS_RESET = 4'h0;
	localparam logic [7:0] RD_DATA_RESET = 8'h00;

	// Clock and oscillator timing.
	localparam int MCLK_PERIOD_PS = 5000;
	localparam int OSC_PERIOD_PS = 100000;
	localparam int OSC_CYCLES = OSC_PERIOD_PS / MCLK_PERIOD_PS;
	localparam int PRESCALE_DIV = 1000;
	localparam int TICK_PERIOD_CYCLES = OSC_CYCLES * PRESCALE_DIV;

	// Supply recovery time and data valid delay.
	localparam int SUPPLY_RECOVERY_TIME_US = 10;
	localparam int RECOVERY_CYCLES = (SUPPLY_RECOVERY_TIME_US * 1000000 + MCLK_PERIOD_PS - 1) / MCLK_PERIOD_PS;
	localparam int DATA_VALID_DELAY_US = 1000;
	localparam int DATA_VALID_CYCLES = (DATA_VALID_DELAY_US * 1000000 + MCLK_PERIOD_PS - 1) / MCLK_PERIOD_PS;

	typedef logic [7:0] tick_t;
	typedef logic [9:0] prescale_t;
	typedef logic [4:0] osc_div_t;
	typedef logic [11:0] recover_t;
	typedef logic [17:0] init_count_t;
	typedef logic [15:0] gap_t;

	// Analog supply and integrity monitor levels.
	typedef struct packed {
		logic supply_low;
		logic analog_regulator_fault;
		logic digital_regulator_fault;
		logic otp_regulator_fault;
		logic edge_seal_break;
	} supply_mon_t;

	// Pressure path DSP status levels.
	typedef struct packed {
		logic selftest_unfinished;
		logic common_mode_fault;
		logic selftest_fault;
	} dsp_stat_t;

	// Memory and temperature fault event pulses.
	typedef struct packed {
		logic factory_otp;
		logic user_otp;
		logic user_rw;
		logic temperature_range_fault;
	} mem_evt_t;

endpackage

/* File: rtl/tick_counter.sv */
/*
 Free-running rolling tick counter with oscillator divider and 10-bit prescaler.
 Assumes an active-low reset whose release is already synchronised to mclk.
*/
`timescale 1ns/1ps
module tick_counter #(
	parameter int OSC_CYCLES = status_tick_pkg::OSC_CYCLES,
	parameter int PRESCALE_DIV = status_tick_pkg::PRESCALE_DIV
) (
	input wire logic mclk,
	input wire logic rst_n,
	output status_tick_pkg::tick_t count_q
);
	status_tick_pkg::osc_div_t osc_q;
	status_tick_pkg::prescale_t pre_q;
	wire osc_tick = (osc_q == status_tick_pkg::osc_div_t'(OSC_CYCLES - 1));
	wire pre_wrap = osc_tick && (pre_q == status_tick_pkg::prescale_t'(PRESCALE_DIV - 1));

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			osc_q <= '0;
			pre_q <= '0;
			count_q <= status_tick_pkg::TICK_RESET; // RULE20
		end else begin
			osc_q <= osc_tick ? '0 : osc_q + 1'b1;
			if (osc_tick) begin
				pre_q <= pre_wrap ? '0 : pre_q + 1'b1; // RULE2
			end
			if (pre_wrap) begin
				count_q <= count_q + 1'b1; // RULE2
			end
		end
	end
endmodule

/* File: sim/host_reader.sv */
/*
 Host controller model that reads the status and tick registers over the block's read port.
 Assumes the caller waits for reset release before the first read.
*/
`timescale 1ns/1ps
module host_reader (
	input wire logic mclk,
	input wire logic init_busy,
	output logic rd_req,
	output logic [7:0] rd_addr,
	input wire logic [7:0] rd_data_q,
	input wire logic rd_valid_q,
	output logic supply_trusted
);
	int idle_cycles = 0;

	initial begin
		rd_req = 1'b0;
		rd_addr = 8'h00;
	end

	// Supply flags are not trusted while the device is still initialising.
	assign supply_trusted = !init_busy;

	// One read; the address is inverted once released so a stale value never looks valid.
	task automatic read(input logic [7:0] a, output logic [7:0] d);
		d = 'x;
		repeat (idle_cycles) @(posedge mclk);
		@(posedge mclk);
		rd_req <= 1'b1;
		rd_addr <= a;
		@(posedge mclk);
		rd_req <= 1'b0;
		rd_addr <= ~a;
		for (int i = 0; i < 4; i++) begin
			#1;
			if (rd_valid_q === 1'b1) begin
				d = rd_data_q;
				break;
			end
			@(posedge mclk);
		end
	endtask
endmodule

/* File: sim/status_and_tick_registers_tb_top.sv */
/*
 Self-checking testbench for the status and tick register block.
 Assumes a 200 MHz clock and a shortened data valid delay.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
	$display("[ERR] %s expected %h seen %h", nm, e, g); end end
module status_and_tick_registers_tb_top;
	localparam int DV = 50;
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	logic rd_req;
	logic [7:0] rd_addr;
	logic [7:0] rd_data_q;
	logic rd_valid_q;
	status_tick_pkg::supply_mon_t supply_mon = '0;
	logic supply_report_disable = 1'b1;
	status_tick_pkg::dsp_stat_t dsp_stat = 3'h1;
	logic comm_fault_flag = 1'b0;
	status_tick_pkg::mem_evt_t mem_evt = '0;
	logic otp_write_busy = 1'b0;
	logic test_enter = 1'b0;
	logic test_exit = 1'b0;
	logic summary_reported = 1'b0;
	logic memtemp_reported = 1'b0;
	logic test_active_flag_q;
	logic initializing_flag_q;
	logic supply_trusted;
	logic [7:0] t0;
	logic [7:0] t;
	int n;
	int n_fail = 0;
	int total_checks = 0;

	always #2.5 mclk = ~mclk;

	status_and_tick_registers #(.DATA_VALID_CYCLES(DV)) DUT (.mclk(mclk), .nrst(nrst), .rd_req(rd_req),
		.rd_addr(rd_addr), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q), .supply_mon(supply_mon),
		.supply_report_disable(supply_report_disable), .dsp_stat(dsp_stat), .comm_fault_flag(comm_fault_flag),
		.mem_evt(mem_evt), .otp_write_busy(otp_write_busy), .test_enter(test_enter), .test_exit(test_exit),
		.summary_reported(summary_reported), .memtemp_reported(memtemp_reported),
		.test_active_flag_q(test_active_flag_q), .initializing_flag_q(initializing_flag_q));

	host_reader host (.mclk(mclk), .init_busy(initializing_flag_q), .rd_req(rd_req), .rd_addr(rd_addr),
		.rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q), .supply_trusted(supply_trusted));

	task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
		logic [7:0] d;
		host.read(a, d);
		`CHK(nm, e, d)
	endtask

	// One-cycle pulse on {test_enter, test_exit, summary_reported, memtemp_reported}, picked by sel.
	task automatic pulse(input logic [3:0] sel);
		@(posedge mclk);
		{test_enter, test_exit, summary_reported, memtemp_reported} <= sel;
		@(posedge mclk);
		{test_enter, test_exit, summary_reported, memtemp_reported} <= 4'h0;
		repeat (2) @(posedge mclk);
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	initial begin
		repeat (60000) @(posedge mclk);
		n_fail++;
		$display("[ERR] watchdog expected done seen timeout");
		wrap_up();
	end

	initial begin
		repeat (12) @(posedge mclk);
		nrst <= 1'b1;
		repeat (3) @(posedge mclk);
		rd(status_tick_pkg::ADDR_TICK, 8'h00, "tick reset");
		rd(status_tick_pkg::ADDR_SUMMARY, 8'h83, "summary reset");
		rd(status_tick_pkg::ADDR_SUMMARY, 8'h81, "summary after read");
		`CHK("init early", 1'b1, initializing_flag_q)
		repeat (DV) @(posedge mclk);
		`CHK("init done", 1'b0, initializing_flag_q)
		`CHK("supply trusted", 1'b1, supply_trusted)
		rd(status_tick_pkg::ADDR_SUMMARY, 8'h80, "summary ready");
		rd(8'h7f, 8'h00, "unmapped");
		host.idle_cycles = 3;
		for (int i = 0; i < 4; i++) begin
			@(posedge mclk);
			dsp_stat <= (i == 3) ? 3'h0 : 3'(1 << i);
			rd(status_tick_pkg::ADDR_SUMMARY, (i == 3) ? 8'h00 : 8'h80, "dsp fault");
		end
		host.idle_cycles = 0;
		@(posedge mclk);
		comm_fault_flag <= 1'b1;
		rd(status_tick_pkg::ADDR_SUMMARY, 8'h20, "comm fault");
		@(posedge mclk);
		comm_fault_flag <= 1'b0;
		pulse(4'h8);
		`CHK("test on", 1'b1, test_active_flag_q)
		rd(status_tick_pkg::ADDR_SUMMARY, 8'h04, "test summary");
		pulse(4'h4);
		rd(status_tick_pkg::ADDR_SUMMARY, 8'h00, "test off");
		for (int i = 0; i < 5; i++) begin
			@(posedge mclk);
			supply_mon <= 5'(1 << i);
			repeat (4) @(posedge mclk);
			rd(status_tick_pkg::ADDR_SUPPLY, (i == 4) ? 8'h80 : 8'(1 << i), "supply bit");
			rd(status_tick_pkg::ADDR_SUMMARY, 8'h08, "supply summary");
			@(posedge mclk);
			supply_mon <= '0;
			repeat (4) @(posedge mclk);
			rd(status_tick_pkg::ADDR_SUPPLY, 8'h00, "supply follow");
		end
		@(posedge mclk);
		supply_report_disable <= 1'b0;
		supply_mon <= 5'h10;
		repeat (4) @(posedge mclk);
		supply_mon <= '0;
		repeat (100) @(posedge mclk);
		rd(status_tick_pkg::ADDR_SUPPLY, 8'h80, "supply held");
		repeat (2000) @(posedge mclk);
		rd(status_tick_pkg::ADDR_SUPPLY, 8'h00, "supply recovered");
		for (int i = 0; i < 4; i++) begin
			@(posedge mclk);
			mem_evt <= 4'(1 << i);
			@(posedge mclk);
			mem_evt <= '0;
			rd(status_tick_pkg::ADDR_SUMMARY, 8'h10, "mem summary");
			rd(status_tick_pkg::ADDR_MEMTEMP, (i == 0) ? 8'h04 : 8'(8'h10 << i), "mem bit");
			rd(status_tick_pkg::ADDR_MEMTEMP, 8'h00, "mem cleared");
		end
		@(posedge mclk);
		mem_evt <= 4'h1;
		@(posedge mclk);
		mem_evt <= '0;
		pulse(4'h1);
		rd(status_tick_pkg::ADDR_MEMTEMP, 8'h00, "mem reported");
		@(posedge mclk);
		otp_write_busy <= 1'b1;
		rd(status_tick_pkg::ADDR_MEMTEMP, 8'h10, "write active");
		rd(status_tick_pkg::ADDR_SUMMARY, 8'h10, "write summary");
		@(posedge mclk);
		otp_write_busy <= 1'b0;
		rd(status_tick_pkg::ADDR_MEMTEMP, 8'h00, "write done");
		host.read(status_tick_pkg::ADDR_TICK, t0);
		t = t0;
		n = 0;
		while (t === t0 && n < 12000) begin
			host.read(status_tick_pkg::ADDR_TICK, t);
			n++;
		end
		`CHK("tick step", t0 + 8'h01, t)
		t0 = t;
		n = 0;
		while (t === t0 && n < 12000) begin
			host.read(status_tick_pkg::ADDR_TICK, t);
			n++;
		end
		`CHK("tick next", t0 + 8'h01, t)
		`CHK("tick period", 1'b1, ((n >= 9998) && (n <= 10002)))
		pulse(4'h8);
		@(posedge mclk);
		nrst <= 1'b0;
		repeat (12) @(posedge mclk);
		nrst <= 1'b1;
		repeat (3) @(posedge mclk);
		rd(status_tick_pkg::ADDR_SUMMARY, 8'h03, "summary reset again");
		pulse(4'h2);
		rd(status_tick_pkg::ADDR_SUMMARY, 8'h01, "summary reported");
		wrap_up();
	end
endmodule
